//--- include/pss_pkg.sv
// package of constants and carrier types for the psu status and control block
package pss_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MS_PER_S = 1000;
  // one millisecond tick from the 10 MHz clock
  localparam int unsigned TICK_CYC = CLK_HZ / MS_PER_S;
  // timing figures in milliseconds
  localparam int unsigned ON_DELAY_MIN_MS = 5;
  localparam int unsigned ON_DELAY_MAX_MS = 400;
  localparam int unsigned PG_OFF_MAX_MS = 50;
  localparam int unsigned PG_ON_MIN_MS = 100;
  localparam int unsigned PG_ON_MAX_MS = 500;
  localparam int unsigned PG_LOW_MIN_MS = 100;
  localparam int unsigned LED_HALF_MS = 500;
  // chosen delays, all within the windows above
  localparam int unsigned RAIL_EN_DELAY_MS = 10;
  localparam int unsigned RAIL_WAIT_MAX_MS = 350;
  localparam int unsigned PG_ASSERT_MS = 150;
  localparam int unsigned SYNC_STAGES = 3;

  localparam logic [1:0] LED_OFF = 2'h0;
  localparam logic [1:0] LED_GREEN = 2'h1;
  localparam logic [1:0] LED_YELLOW = 2'h2;

  typedef struct packed {
    logic ac_ok;
    logic main_in_reg;
    logic sb_in_reg;
    logic cur_limit;
    logic ac_lost_long;
    logic internal_fail;
    logic over_current;
    logic over_voltage;
    logic under_voltage;
    logic fan_fail;
    logic temp_warn;
    logic end_of_life;
    logic env_exceeded;
  } pss_status_t;

  typedef struct packed {
    logic green;
    logic yellow;
  } pss_led_t;
endpackage : pss_pkg

//--- rtl/pss_ctrl.sv
// status and control signalling of a front-end power supply
`timescale 1ns/10ps
`default_nettype none
module pss_ctrl
  import pss_pkg::*;
#(
  parameter int unsigned TEMP_W = 8,
  parameter int unsigned PRE_MARGIN = 5,
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // host and backplane pins
  input wire logic on_request_n,
  input wire logic backplane_alert_n,
  input wire logic backplane_fault,
  // internal supply status
  input wire pss_status_t status_in,
  input wire logic [TEMP_W-1:0] probe_temp,
  input wire logic [TEMP_W-1:0] shutdown_temp,
  // power control
  output logic main_rail_en,
  output logic standby_en,
  output logic fan_force_max,
  // signalling pins
  output logic power_good_pin,
  output logic power_good_oe,
  output logic alert_out_n,
  output logic alert_oe,
  output logic thermal_preshutdown_warn,
  output logic [TEMP_W-1:0] temp_report,
  output pss_led_t led
);
  localparam int unsigned MS_W = 10;
  localparam logic [MS_W-1:0] EN_DLY = MS_W'(RAIL_EN_DELAY_MS);
  localparam logic [MS_W-1:0] WAIT_MAX = MS_W'(RAIL_WAIT_MAX_MS);
  localparam logic [MS_W-1:0] PG_DLY = MS_W'(PG_ASSERT_MS);
  localparam logic [MS_W-1:0] PG_LOW = MS_W'(PG_LOW_MIN_MS);
  localparam logic [MS_W-1:0] HALF = MS_W'(LED_HALF_MS);
  localparam int unsigned TK_W = $clog2(TICK_CYCLES + 1);

  initial begin
    if (TICK_CYCLES < 1) $error("tick period must be at least one cycle");
    if (PRE_MARGIN >= (1 << TEMP_W)) $error("margin does not fit temperature width");
    if (RAIL_EN_DELAY_MS < ON_DELAY_MIN_MS || RAIL_WAIT_MAX_MS > ON_DELAY_MAX_MS)
      $error("rail delay outside window");
    if (PG_ASSERT_MS < PG_ON_MIN_MS || PG_ASSERT_MS > PG_ON_MAX_MS) $error("power good delay outside window");
    if (PG_OFF_MAX_MS < 1) $error("power good off bound too small");
  end

  typedef enum logic [2:0] {
    ST_OFF, ST_RAMP, ST_WAIT_REG, ST_PG_DELAY, ST_ON, ST_FAULT
  } pss_state_t;

  pss_state_t state_q;
  logic on_req_s;
  logic bp_alert_s;
  logic bp_fault_s;
  logic [TK_W-1:0] tick_cnt_q;
  logic tick_q;
  logic [MS_W-1:0] ms_cnt_q;
  logic [MS_W-1:0] pg_low_cnt_q;
  logic [MS_W-1:0] blink_cnt_q;
  logic blink_q;
  logic critical;
  logic warning;
  logic pre_warn;
  logic pg_allowed;
  logic on_req_q;
  pss_led_t led_d;

  pss_sync #(.WIDTH(3), .INIT(3'h3)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .async_in({on_request_n, backplane_alert_n, backplane_fault}),
    .sync_out({on_req_s, bp_alert_s, bp_fault_s})
  );

  // decode used by the rail sequence and power good
  function automatic logic rail_reg_ok(input pss_status_t s);
    return s.main_in_reg && s.sb_in_reg && !s.under_voltage;
  endfunction

  // single free-running millisecond tick
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else if (clk_en) begin
      if (tick_cnt_q == TK_W'(TICK_CYCLES - 1)) begin
        tick_cnt_q <= '0;
        tick_q <= 1'b1;
      end else begin
        tick_cnt_q <= tick_cnt_q + 1'b1;
        tick_q <= 1'b0;
      end
    end
  end

  // pre-shutdown comparator; shutdown below margin saturates to zero
  always_comb begin
    if (shutdown_temp < TEMP_W'(PRE_MARGIN)) begin
      pre_warn = 1'b1;
    end else begin
      pre_warn = probe_temp >= (shutdown_temp - TEMP_W'(PRE_MARGIN));
    end
  end

  // critical events shut down; warnings only signal
  assign critical = status_in.internal_fail | status_in.over_current | status_in.over_voltage
                  | status_in.under_voltage | status_in.fan_fail | bp_fault_s;
  assign warning = status_in.temp_warn | pre_warn | status_in.end_of_life | status_in.env_exceeded;
  assign pg_allowed = rail_reg_ok(status_in) && !status_in.ac_lost_long && !status_in.internal_fail;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      on_req_q <= 1'b0;
    end else if (clk_en) begin
      on_req_q <= !on_req_s;
    end
  end

  // power sequence
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_OFF;
      ms_cnt_q <= '0;
    end else if (clk_en) begin
      if (on_req_s || bp_fault_s || !status_in.ac_ok) begin
        // a latched fault clears by toggling the request or losing ac
        state_q <= (bp_fault_s && !on_req_s && status_in.ac_ok) ? ST_FAULT : ST_OFF;
        ms_cnt_q <= '0;
      end else begin
        unique case (state_q)
          ST_OFF: begin
            if (on_req_q && pg_low_cnt_q >= PG_LOW) begin
              state_q <= ST_RAMP;
              ms_cnt_q <= '0;
            end
          end
          ST_RAMP: begin
            if (tick_q) ms_cnt_q <= ms_cnt_q + 1'b1;
            if (ms_cnt_q >= EN_DLY) begin
              state_q <= ST_WAIT_REG;
              ms_cnt_q <= '0;
            end
          end
          ST_WAIT_REG: begin
            if (tick_q) ms_cnt_q <= ms_cnt_q + 1'b1;
            if (critical) begin
              state_q <= ST_FAULT;
            end else if (rail_reg_ok(status_in) && !status_in.cur_limit) begin
              state_q <= ST_PG_DELAY;
              ms_cnt_q <= '0;
            end else if (ms_cnt_q >= WAIT_MAX) begin
              state_q <= ST_FAULT;
            end
          end
          ST_PG_DELAY: begin
            if (critical || !pg_allowed) begin
              state_q <= critical ? ST_FAULT : ST_WAIT_REG;
              ms_cnt_q <= '0;
            end else if (status_in.cur_limit) begin
              ms_cnt_q <= '0;
            end else begin
              if (tick_q) ms_cnt_q <= ms_cnt_q + 1'b1;
              if (ms_cnt_q >= PG_DLY) state_q <= ST_ON;
            end
          end
          ST_ON: begin
            if (critical) state_q <= ST_FAULT;
            else if (!pg_allowed) state_q <= ST_WAIT_REG;
          end
          ST_FAULT: state_q <= ST_FAULT;
          default: state_q <= ST_OFF;
        endcase
      end
    end
  end

  // time power good has been low; gates the next turn-on
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_low_cnt_q <= '0;
    end else if (clk_en) begin
      if (state_q == ST_ON) begin
        pg_low_cnt_q <= '0;
      end else if (tick_q && pg_low_cnt_q < PG_LOW) begin
        pg_low_cnt_q <= pg_low_cnt_q + 1'b1;
      end
    end
  end

  // power outputs; standby stays on regardless of request
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      main_rail_en <= 1'b0;
      standby_en <= 1'b0;
      fan_force_max <= 1'b0;
    end else if (clk_en) begin
      // rail held off through the ramp delay so regulation can never come before 5 ms
      main_rail_en <= !on_req_s && !bp_fault_s && status_in.ac_ok
                      && (state_q inside {ST_WAIT_REG, ST_PG_DELAY, ST_ON});
      standby_en <= status_in.ac_ok;
      fan_force_max <= !bp_alert_s;
    end
  end

  // power good open drain: drive low unless good; drop at once on request removal
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_good_pin <= 1'b0;
      power_good_oe <= 1'b1;
    end else if (clk_en) begin
      power_good_pin <= 1'b0;
      power_good_oe <= !(state_q == ST_ON && pg_allowed && !on_req_s && !critical);
    end
  end

  // alert open drain and thermal report
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      alert_out_n <= 1'b0;
      alert_oe <= 1'b0;
      thermal_preshutdown_warn <= 1'b0;
      temp_report <= '0;
    end else if (clk_en) begin
      alert_out_n <= 1'b0;
      alert_oe <= critical | warning;
      thermal_preshutdown_warn <= pre_warn;
      temp_report <= probe_temp;
    end
  end

  // half-second phase for both flashing patterns
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (clk_en && tick_q) begin
      if (blink_cnt_q == HALF - 1'b1) begin
        blink_cnt_q <= '0;
        blink_q <= !blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
    end
  end

  // led priority: fail, warning, on, standby
  always_comb begin
    led_d = '0;
    if (!status_in.ac_ok) begin
      led_d = '0;
    end else if (critical || state_q == ST_FAULT) begin
      led_d.yellow = 1'b1;
    end else if (warning) begin
      led_d.yellow = blink_q;
      led_d.green = !blink_q;
    end else if (state_q == ST_ON) begin
      led_d.green = 1'b1;
    end else begin
      led_d.green = blink_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      led <= '0;
    end else if (clk_en) begin
      led <= led_d;
    end
  end
endmodule : pss_ctrl
`default_nettype wire

//--- rtl/pss_sync.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module pss_sync
  import pss_pkg::*;
#(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  initial begin
    if (WIDTH < 1) $error("pss_sync width must be at least one");
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else if (clk_en) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts only once stage two and three agree
  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync_out[i] <= INIT[i];
        end else if (clk_en && (s2_q[i] == s3_q[i])) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate
endmodule : pss_sync
`default_nettype wire

//--- tb/pss_ctrl_sva.sv
// assertion checker for the psu status and control block
`timescale 1ns/10ps
`default_nettype none
module pss_ctrl_sva
  import pss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // pins and status
  input wire logic on_request_n,
  input wire logic backplane_alert_n,
  input wire logic backplane_fault,
  input wire pss_status_t status_in,
  // outputs
  input wire logic main_rail_en,
  input wire logic fan_force_max,
  input wire logic power_good_oe,
  input wire logic alert_oe,
  input wire pss_led_t led
);
  localparam int MS = TICK_CYCLES;
  int reg_q;
  int low_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // regulation time restarts whenever current limit is seen
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_q <= 0;
      low_q <= 0;
    end else begin
      reg_q <= (status_in.main_in_reg && !status_in.cur_limit) ? reg_q + 1 : 0;
      low_q <= power_good_oe ? low_q + 1 : 0;
    end
  end
  pg_in_reg_a: assert property (!power_good_oe |-> $past(status_in.main_in_reg && status_in.sb_in_reg))
    else $error("power good outside regulation");
  pg_on_min_a: assert property ($fell(power_good_oe) |-> reg_q >= 100 * MS)
    else $error("power good too early");
  pg_on_max_a: assert property ($fell(power_good_oe) |-> reg_q <= 500 * MS)
    else $error("power good too late");
  pg_low_min_a: assert property ($fell(power_good_oe) |-> low_q >= 100 * MS)
    else $error("power good low too short");
  rail_on_a: assert property ($rose(main_rail_en) |-> !$past(on_request_n, 4))
    else $error("rail on without request");
  rail_off_a: assert property (on_request_n [*8] |-> !main_rail_en && power_good_oe)
    else $error("rail stays on without request");
  fault_off_a: assert property (backplane_fault [*8] |-> !main_rail_en)
    else $error("rail on during backplane fault");
  fan_max_a: assert property (!backplane_alert_n [*8] |-> fan_force_max)
    else $error("fan not forced");
  alert_set_a: assert property ((status_in.fan_fail || status_in.over_voltage || status_in.temp_warn)
    |-> ##[1:2] alert_oe)
    else $error("alert missing");
  led_dark_a: assert property (!status_in.ac_ok [*3] |-> !led.green && !led.yellow)
    else $error("led lit without ac");
  led_fail_a: assert property ((status_in.ac_ok && status_in.internal_fail) [*3] |-> led.yellow && !led.green)
    else $error("led not yellow on failure");
endmodule : pss_ctrl_sva
`default_nettype wire

//--- tb/pss_ctrl_tb.sv
// self-checking testbench of the psu status and control block
`timescale 1ns/10ps
`default_nettype none
module pss_ctrl_tb;
  import pss_pkg::*;
  localparam int T = 4;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clk_en = 1'b1;
  logic req_on = 1'b0;
  logic [9:0] rise_ms = 10'h0;
  logic backplane_alert_n = 1'b1;
  logic backplane_fault = 1'b0;
  logic [7:0] probe_temp = 8'h0;
  logic [7:0] shutdown_temp = 8'hc8;
  logic on_request_n, rail_ok, main_rail_en, fan_force_max, power_good_pin, power_good_oe;
  logic alert_out_n, alert_oe, warn;
  logic [7:0] temp_report;
  pss_status_t st = '0;
  pss_status_t st_dut;
  pss_led_t led, led_a;
  int error_cnt = 0;
  int comparisons = 0;
  int seed = 26759;
  int n;
  // open-drain wires resolved against their pull-ups
  wire logic pg_w = power_good_oe ? power_good_pin : 1'b1;
  wire logic al_w = alert_oe ? alert_out_n : 1'b1;
  assign st_dut = {st[12], rail_ok, st[10:0]};
  pss_host_model #(.TICK_CYCLES(T)) pss_host_model_i (.ref_clk, .req_on, .rise_ms, .main_rail_en,
    .on_request_n, .main_in_reg(rail_ok));
  pss_ctrl #(.TICK_CYCLES(T)) pss_ctrl_i (.ref_clk, .rst_b, .clk_en, .on_request_n, .backplane_alert_n,
    .backplane_fault, .status_in(st_dut), .probe_temp, .shutdown_temp, .main_rail_en, .standby_en(),
    .fan_force_max, .power_good_pin, .power_good_oe, .alert_out_n, .alert_oe,
    .thermal_preshutdown_warn(warn), .temp_report, .led);
  initial forever #50 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic cyc(input int c);
    repeat (c) @(negedge ref_clk);
  endtask : cyc
  // expected cycles from request to power good
  function automatic int pg_cyc(input int rise, input int cl);
    int m;
    // rail is enabled only after the ramp delay, so its rise adds to it
    m = RAIL_EN_DELAY_MS + rise;
    m = m > cl ? m : cl;
    return (m + PG_ASSERT_MS) * T;
  endfunction : pg_cyc
  task automatic power_on(input int rise, input int cl);
    int lo;
    lo = pg_cyc(rise, cl);
    rise_ms = 10'(rise);
    st.cur_limit = cl > 0;
    req_on = 1'b1;
    n = 0;
    while (pg_w !== 1'b1 && n < 8000) begin
      cyc(1);
      n++;
      if (n == cl * T) st.cur_limit = 1'b0;
    end
    chk("pg_delay", 8'(n >= lo - T && n <= lo + 4 * T), 8'h1);
    chk("rail_on", 8'(main_rail_en), 8'h1);
    chk("led_on", 8'(led), 8'h2);
    chk("alert_idle", 8'(al_w), 8'h1);
  endtask : power_on
  task automatic power_off();
    req_on = 1'b0;
    n = 0;
    while (pg_w !== 1'b0 && n < 1000) begin
      cyc(1);
      n++;
    end
    chk("pg_off", 8'(n <= PG_OFF_MAX_MS * T), 8'h1);
    cyc(10);
    chk("rail_off", 8'(main_rail_en), 8'h0);
    cyc(120 * T);
  endtask : power_off
  // a full flash period is 1000 ms, so half of it apart every flashing colour has toggled
  task automatic flash(input logic [1:0] x);
    led_a = led;
    cyc(LED_HALF_MS * T);
    chk("led_flip", 8'(led_a ^ led), 8'(x));
    chk("led_both", 8'(led_a & led), 8'h0);
  endtask : flash
  initial begin
    repeat (80000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
  initial begin
    cyc(16);
    rst_b = 1'b1;
    cyc(2);
    chk("rail_rst", 8'(main_rail_en), 8'h0);
    chk("pg_rst", 8'(pg_w), 8'h0);
    chk("led_dark", 8'(led), 8'h0);
    st.ac_ok = 1'b1;
    st.sb_in_reg = 1'b1;
    cyc(4);
    // enable low must freeze the flash phase
    led_a = led;
    clk_en = 1'b0;
    cyc(LED_HALF_MS * T);
    chk("freeze", 8'(led_a ^ led), 8'h0);
    clk_en = 1'b1;
    cyc(4);
    flash(2'h2);
    for (int i = 0; i < 2; i++) begin
      power_on(i == 0 ? 2 : 11 + $unsigned($random(seed)) % 290, i * 200);
      power_off();
    end
    power_on(5, 0);
    shutdown_temp = 8'(20 + $unsigned($random(seed)) % 200);
    probe_temp = shutdown_temp - 8'h6;
    cyc(3);
    chk("pre_off", 8'(warn), 8'h0);
    probe_temp = probe_temp + 8'h1;
    cyc(3);
    chk("pre_on", 8'(warn), 8'h1);
    chk("temp_rep", temp_report, probe_temp);
    chk("alert_pre", 8'(al_w), 8'h0);
    flash(2'h3);
    probe_temp = 8'h0;
    // temp warning stays on through the failures to test priority
    for (int b = 0; b < 8; b++) begin
      st[b] = 1'b1;
      cyc(4);
      chk("alert", 8'(al_w), 8'h0);
      if (b > 2) chk("led_fail", 8'(led), 8'h1);
      else flash(2'h3);
      st[b] = (b == 2);
    end
    st[2] = 1'b0;
    backplane_alert_n = 1'b0;
    cyc(10);
    chk("fan_max", 8'(fan_force_max), 8'h1);
    backplane_alert_n = 1'b1;
    cyc(10);
    chk("fan_auto", 8'(fan_force_max), 8'h0);
    power_off();
    power_on(3, 0);
    backplane_fault = 1'b1;
    cyc(10);
    chk("fault_rail", 8'(main_rail_en), 8'h0);
    chk("fault_pg", 8'(pg_w), 8'h0);
    chk("fault_alert", 8'(al_w), 8'h0);
    st.ac_ok = 1'b0;
    cyc(4);
    chk("led_noac", 8'(led), 8'h0);
    final_report();
  end
endmodule : pss_ctrl_tb
bind pss_ctrl pss_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) pss_ctrl_sva_i (.ref_clk, .rst_b, .on_request_n,
  .backplane_alert_n, .backplane_fault, .status_in, .main_rail_en, .fan_force_max, .power_good_oe, .alert_oe, .led);
`default_nettype wire

//--- tb/pss_host_model.sv
// host request driver and main rail model on the far side
`timescale 1ns/10ps
`default_nettype none
module pss_host_model
  import pss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYC
) (
  // clock
  input wire logic ref_clk,
  // test control
  input wire logic req_on,
  input wire logic [9:0] rise_ms,
  // device side
  input wire logic main_rail_en,
  output logic on_request_n,
  output logic main_in_reg
);
  int cnt_q = 0;
  // driven both ways: a released line is driven high, the level the pull-up would give
  assign on_request_n = req_on ? 1'b0 : 1'b1;
  // slow or fast rise chosen per test; collapses at once on disable
  always_ff @(posedge ref_clk) begin
    cnt_q <= main_rail_en ? cnt_q + 1 : 0;
    main_in_reg <= main_rail_en && (cnt_q >= rise_ms * TICK_CYCLES);
  end
endmodule : pss_host_model
`default_nettype wire
